//--- uarcs_pkg.sv
// constants and types for the utmi attach, reset and chirp link sequencer
package uarcs_pkg;

  // ****************************************
  // utmi field encodings
  // ****************************************
  localparam logic [1:0] LS_SE0 = 2'h0;
  localparam logic [1:0] LS_J = 2'h1;
  localparam logic [1:0] LS_K = 2'h2;
  localparam logic [1:0] XCVR_FS = 2'h2;
  localparam logic [1:0] XCVR_HS = 2'h0;
  localparam logic [1:0] OPM_NORMAL = 2'h0;
  localparam logic [1:0] OPM_CHIRP = 2'h2;
  localparam logic [7:0] SOF_PID = 8'ha5;
  localparam logic [7:0] CHIRP_K_DATA = 8'h00;
  localparam logic [7:0] CHIRP_J_DATA = 8'hff;
  localparam logic [1:0] NUM_PAIRS = 2'h3;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ = 50;
  localparam int T_ATTACH_MAX_MS = 100;
  localparam int T_DEBOUNCE_MS = 100;
  localparam int T_RESET_MS = 10;
  localparam int T_SLOT_MIN_US = 40;
  localparam int T_SLOT_MAX_US = 60;
  localparam int DEBOUNCE_CYC = T_DEBOUNCE_MS * 1000 * CLK_MHZ;
  localparam int RESET_CYC = T_RESET_MS * 1000 * CLK_MHZ;
  localparam int SLOT_MIN_CYC = T_SLOT_MIN_US * CLK_MHZ;
  localparam int SLOT_MAX_CYC = T_SLOT_MAX_US * CLK_MHZ;
  localparam int SLOT_CYC = (SLOT_MIN_CYC + SLOT_MAX_CYC) / 2;
  localparam int CHIRP_K_CYC = 66000;
  localparam int FILT_CYC = 165;
  localparam int TMR_W = 23;

  // ****************************************
  // control and status registers
  // ****************************************
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STAT = 4'h4;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_HOST_BIT = 1;
  localparam int CTRL_RESTART_BIT = 2;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_PAIRS_LSB = 4;
  localparam int STAT_HS_BIT = 6;
  localparam int STAT_LS_LSB = 8;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_H_PWR = 4'h1,
    ST_H_RST = 4'h2,
    ST_H_KSEEN = 4'h3,
    ST_H_CHIRP = 4'h4,
    ST_H_END = 4'h5,
    ST_H_SOF = 4'h6,
    ST_H_RUN = 4'h7,
    ST_D_ATT = 4'h8,
    ST_D_CHIRP = 4'h9,
    ST_D_PAIRS = 4'ha,
    ST_D_HS = 4'hb
  } uarcs_state_type;

  typedef struct packed {
    logic [1:0] xcvr_sel;
    logic term_sel;
    logic [1:0] opmode;
    logic tx_valid;
    logic [7:0] tx_data;
    logic dp_pulldown;
    logic dm_pulldown;
    logic vbus_drive;
  } uarcs_utmi_type;

endpackage

//--- uarcs_ls_filt.sv
// line state filter: a value counts once held for a number of cycles
`timescale 1ns/100ps
`default_nettype none
module uarcs_ls_filt #(
  parameter int HOLD = 165
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] ls_in,
  output logic [1:0] ls_val,
  output logic held,
  output logic hit
);
  localparam int CW = $clog2(HOLD + 1);
  localparam logic [CW-1:0] HOLD_C = CW'(HOLD);
  logic [CW-1:0] cnt_r;
  logic [1:0] prev_r;
  logic hit_r;

  // continuous hold before a value counts
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_r <= 2'h0;
      cnt_r <= '0;
    end else if (ls_in != prev_r) begin
      prev_r <= ls_in;
      cnt_r <= '0;
    end else if (cnt_r != HOLD_C) begin
      cnt_r <= cnt_r + CW'(1);
    end
  end

  // one pulse per qualified value, so alternations are counted once
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hit_r <= 1'b0;
    end else begin
      hit_r <= (ls_in == prev_r) && (cnt_r == HOLD_C - CW'(1));
    end
  end

  assign ls_val = prev_r;
  assign held = (cnt_r == HOLD_C);
  assign hit = hit_r;
endmodule
`default_nettype wire

//--- uarcs_seq.sv
// link sequencer for attach, bus reset and chirp over a utmi+ transceiver
`timescale 1ns/100ps
`default_nettype none
module uarcs_seq import uarcs_pkg::*; #(
  parameter int DEB_CYC = DEBOUNCE_CYC,
  parameter int RST_CYC = RESET_CYC,
  parameter int CHK_CYC = CHIRP_K_CYC,
  parameter int FLT_CYC = FILT_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic vbus_valid,
  input wire logic [1:0] line_state,
  input wire logic tx_ready,
  output uarcs_utmi_type utmi
);

  // ****************************************
  // register port
  // ****************************************
  logic en_r;
  logic host_r;
  logic restart_r;
  logic [31:0] rdata_r;
  uarcs_state_type st_r;
  uarcs_state_type st_nxt;
  logic [1:0] pair_r;
  logic [1:0] ls_val;
  logic ls_held;
  logic ls_hit;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      en_r <= 1'b0;
      host_r <= 1'b0;
    end else if (wr && addr == ADDR_CTRL) begin
      en_r <= wdata[CTRL_EN_BIT];
      host_r <= wdata[CTRL_HOST_BIT];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      restart_r <= 1'b0;
    end else begin
      restart_r <= wr && addr == ADDR_CTRL && wdata[CTRL_RESTART_BIT];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_r <= 32'h0;
    end else if (rd && addr == ADDR_CTRL) begin
      rdata_r <= {30'h0, host_r, en_r};
    end else if (rd && addr == ADDR_STAT) begin
      rdata_r <= {22'h0, ls_val, 1'b0,
                  st_r == ST_D_HS || st_r == ST_H_RUN, pair_r, st_r};
    end else begin
      rdata_r <= 32'h0;
    end
  end
  assign rdata = rdata_r;

  // ****************************************
  // line state filter and timers
  // ****************************************
  uarcs_ls_filt #(.HOLD(FLT_CYC)) u_filt (
    .clk(clk),
    .rst(rst),
    .ls_in(line_state),
    .ls_val(ls_val),
    .held(ls_held),
    .hit(ls_hit)
  );

  localparam logic [TMR_W-1:0] TMR_MAX = '1;
  localparam logic [TMR_W-1:0] DEB_C = TMR_W'(DEB_CYC - 1);
  localparam logic [TMR_W-1:0] CHK_C = TMR_W'(CHK_CYC - 1);
  localparam logic [TMR_W-1:0] SLOT_C = TMR_W'(SLOT_CYC - 1);
  localparam logic [TMR_W-1:0] RST_C = TMR_W'(RST_CYC - 1);
  logic [TMR_W-1:0] tmr_r;
  logic [TMR_W-1:0] rst_tmr_r;
  logic phase_r;
  logic expect_j_r;
  logic rst_done;
  logic lost;
  logic j_held;
  assign rst_done = (rst_tmr_r == RST_C);
  assign j_held = ls_held && ls_val == LS_J;
  // the host only sees its own vbus once it has powered the port
  assign lost = !vbus_valid && st_r != ST_IDLE && st_r != ST_H_PWR;

  // per-state timer; in host power-up it only runs while J stands
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tmr_r <= '0;
    end else if (st_nxt != st_r) begin
      tmr_r <= '0;
    end else if (st_r == ST_H_PWR && !j_held) begin
      tmr_r <= '0;
    end else if (st_r == ST_H_CHIRP && tmr_r == SLOT_C) begin
      tmr_r <= '0;
    end else if (tmr_r != TMR_MAX) begin
      tmr_r <= tmr_r + TMR_W'(1);
    end
  end

  // reset period timer spans the whole chirp exchange
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rst_tmr_r <= '0;
    end else if (st_r == ST_H_RST || st_r == ST_H_KSEEN ||
                 st_r == ST_H_CHIRP) begin
      if (!rst_done) begin
        rst_tmr_r <= rst_tmr_r + TMR_W'(1);
      end
    end else begin
      rst_tmr_r <= '0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_r <= 1'b0;
    end else if (st_r != ST_H_CHIRP) begin
      phase_r <= 1'b0;
    end else if (tmr_r == SLOT_C) begin
      phase_r <= !phase_r;
    end
  end

  // any break in the K-J alternation restarts the count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pair_r <= 2'h0;
      expect_j_r <= 1'b0;
    end else if (st_r != ST_D_PAIRS) begin
      pair_r <= 2'h0;
      expect_j_r <= 1'b0;
    end else if (ls_hit) begin
      if (expect_j_r && ls_val == LS_J) begin
        pair_r <= pair_r + 2'h1;
        expect_j_r <= 1'b0;
      end else if (!expect_j_r && ls_val == LS_K) begin
        expect_j_r <= 1'b1;
      end else begin
        pair_r <= 2'h0;
        expect_j_r <= (ls_val == LS_K);
      end
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    // restart, disable or vbus loss go back to idle
    if (!en_r || restart_r || lost) begin
      st_nxt = ST_IDLE;
    end else begin
      unique case (st_r)
        ST_IDLE: begin
          if (host_r) begin
            st_nxt = ST_H_PWR;
          end else if (vbus_valid) begin
            st_nxt = ST_D_ATT;
          end
        end
        // attach seen as a steady J, debounced
        ST_H_PWR: begin
          if (tmr_r >= DEB_C) begin
            st_nxt = ST_H_RST;
          end
        end
        ST_H_RST: begin
          if (ls_hit && ls_val == LS_K) begin
            st_nxt = ST_H_KSEEN;
          end
        end
        ST_H_KSEEN: begin
          if (ls_hit && ls_val == LS_SE0) begin
            st_nxt = ST_H_CHIRP;
          end
        end
        // chirps end with the reset period
        ST_H_CHIRP: begin
          if (rst_done) begin
            st_nxt = ST_H_END;
          end
        end
        ST_H_END: st_nxt = ST_H_SOF;
        ST_H_SOF: begin
          if (tx_ready) begin
            st_nxt = ST_H_RUN;
          end
        end
        ST_H_RUN: st_nxt = ST_H_RUN;
        // debounce, then driven SE0 is a bus reset
        ST_D_ATT: begin
          if (tmr_r >= DEB_C && ls_held && ls_val == LS_SE0) begin
            st_nxt = ST_D_CHIRP;
          end
        end
        ST_D_CHIRP: begin
          if (tmr_r == CHK_C) begin
            st_nxt = ST_D_PAIRS;
          end
        end
        // third pair completes on its J
        ST_D_PAIRS: begin
          if (ls_hit && ls_val == LS_J && expect_j_r &&
              pair_r == NUM_PAIRS - 2'h1) begin
            st_nxt = ST_D_HS;
          end
        end
        ST_D_HS: st_nxt = ST_D_HS;
        default: st_nxt = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= ST_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // transceiver controls
  // ****************************************
  uarcs_utmi_type ctl_nxt;
  uarcs_utmi_type ctl_r;

  always_comb begin
    ctl_nxt = '0;
    ctl_nxt.xcvr_sel = XCVR_FS;
    ctl_nxt.opmode = OPM_NORMAL;
    ctl_nxt.dp_pulldown = host_r;
    ctl_nxt.dm_pulldown = host_r;
    // host idles full-speed with termination high
    ctl_nxt.term_sel = host_r && st_nxt == ST_IDLE;
    unique case (st_nxt)
      ST_IDLE: ;
      ST_H_PWR: begin
        ctl_nxt.vbus_drive = 1'b1;
        ctl_nxt.term_sel = 1'b1;
      end
      ST_H_RST, ST_H_END, ST_H_RUN: begin
        ctl_nxt.vbus_drive = 1'b1;
        ctl_nxt.xcvr_sel = XCVR_HS;
      end
      ST_H_KSEEN: begin
        ctl_nxt.vbus_drive = 1'b1;
        ctl_nxt.xcvr_sel = XCVR_HS;
        ctl_nxt.opmode = OPM_CHIRP;
      end
      ST_H_CHIRP: begin
        ctl_nxt.vbus_drive = 1'b1;
        ctl_nxt.xcvr_sel = XCVR_HS;
        ctl_nxt.opmode = OPM_CHIRP;
        ctl_nxt.tx_valid = 1'b1;
        ctl_nxt.tx_data = phase_nxt() ? CHIRP_J_DATA : CHIRP_K_DATA;
      end
      ST_H_SOF: begin
        ctl_nxt.vbus_drive = 1'b1;
        ctl_nxt.xcvr_sel = XCVR_HS;
        ctl_nxt.tx_valid = 1'b1;
        ctl_nxt.tx_data = SOF_PID;
      end
      // pull-up on at once, well inside the attach limit
      ST_D_ATT: ctl_nxt.term_sel = 1'b1;
      // chirp K, stuffing and NRZI off
      ST_D_CHIRP: begin
        ctl_nxt.xcvr_sel = XCVR_HS;
        ctl_nxt.term_sel = 1'b1;
        ctl_nxt.opmode = OPM_CHIRP;
        ctl_nxt.tx_valid = 1'b1;
        ctl_nxt.tx_data = CHIRP_K_DATA;
      end
      // dropping valid returns the bus to SE0
      ST_D_PAIRS: begin
        ctl_nxt.xcvr_sel = XCVR_HS;
        ctl_nxt.term_sel = 1'b1;
        ctl_nxt.opmode = OPM_CHIRP;
      end
      ST_D_HS: ctl_nxt.xcvr_sel = XCVR_HS;
      default: ;
    endcase
  end

  // phase that the chirp timer will hold after this edge
  function automatic logic phase_nxt();
    return (st_r == ST_H_CHIRP && tmr_r == SLOT_C) ? !phase_r : phase_r;
  endfunction

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctl_r <= '0;
      ctl_r.xcvr_sel <= XCVR_FS;
    end else begin
      ctl_r <= ctl_nxt;
    end
  end
  assign utmi = ctl_r;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // registered pins trail a role write by one edge
  role_pulldown_a: assert property (
    st_r != ST_IDLE |-> utmi.dp_pulldown == $past(host_r) &&
                        utmi.dm_pulldown == $past(host_r))
    else $error("pull-downs do not match role");
  idle_fs_a: assert property (
    st_r == ST_IDLE |-> utmi.xcvr_sel == XCVR_FS && !utmi.tx_valid)
    else $error("idle not full-speed or transmitting");
  vbus_loss_a: assert property (
    lost |=> st_r == ST_IDLE)
    else $error("vbus loss did not return idle");
  dev_attach_a: assert property (
    $rose(st_r == ST_D_ATT) |-> $past(vbus_valid) && utmi.term_sel &&
                                utmi.xcvr_sel == XCVR_FS)
    else $error("attach without pull-up");
  chirp_len_a: assert property (
    st_r == ST_D_CHIRP && st_nxt == ST_D_PAIRS |-> tmr_r == CHK_C)
    else $error("chirp k length wrong");
  chirp_mode_a: assert property (
    st_r == ST_D_CHIRP |-> utmi.opmode == OPM_CHIRP && utmi.tx_valid &&
                           utmi.tx_data == CHIRP_K_DATA)
    else $error("chirp k mode wrong");
  hs_switch_a: assert property (
    $rose(st_r == ST_D_HS) |-> $past(pair_r) == NUM_PAIRS - 2'h1 &&
      !utmi.term_sel && utmi.opmode == OPM_NORMAL)
    else $error("high-speed switch wrong");
  bus_reset_a: assert property (
    $rose(st_r == ST_H_RST) |-> utmi.xcvr_sel == XCVR_HS &&
      !utmi.term_sel ##1 !utmi.tx_valid)
    else $error("host bus reset wrong");
  slot_len_a: assert property (
    st_r == ST_H_CHIRP && $past(st_r) == ST_H_CHIRP &&
    $changed(phase_r) |-> $past(tmr_r) == SLOT_C)
    else $error("chirp slot length wrong");
  sof_send_a: assert property (
    $rose(st_r == ST_H_SOF) |-> $past(st_r) == ST_H_END &&
      utmi.tx_valid && utmi.tx_data == SOF_PID)
    else $error("first sof wrong");
  end_normal_a: assert property (
    st_r == ST_H_END |-> $past(rst_done) && !utmi.tx_valid &&
      utmi.opmode == OPM_NORMAL)
    else $error("chirp end wrong");

  dev_hs_c: cover property (st_r == ST_D_PAIRS ##1 st_r == ST_D_HS);
  host_run_c: cover property (st_r == ST_H_SOF ##1 st_r == ST_H_RUN);
  pair_restart_c: cover property ((st_r == ST_D_PAIRS && pair_r == 2'h2) ##1
    (st_r == ST_D_PAIRS && pair_r == 2'h0));
endmodule
`default_nettype wire

//--- uarcs_xcvr_model.sv
// behavioural utmi+ transceiver with the far bus party for the sequencer
`timescale 1ns/100ps
`default_nettype none
module uarcs_xcvr_model import uarcs_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire uarcs_utmi_type utmi,
  input wire logic far_on,
  input wire logic [1:0] far_ls,
  input wire logic far_vbus,
  input wire logic [3:0] rdy_dly,
  output logic [1:0] line_state,
  output logic vbus_valid,
  output logic tx_ready
);
  logic [3:0] tx_cnt_r;

  // ****************************************
  // bus level
  // ****************************************
  // host supply or upstream supply
  assign vbus_valid = utmi.vbus_drive | far_vbus;

  // far party drives far_ls: a full-speed device's dp pull-up reads J on attach, an upstream host drives se0
  // own chirp wins; a released bus with pull-downs reads se0
  always_comb begin
    if (utmi.tx_valid && utmi.opmode == OPM_CHIRP) begin
      line_state = (utmi.tx_data == CHIRP_K_DATA) ? LS_K : LS_J;
    end else if (far_on) begin
      line_state = far_ls;
    end else begin
      line_state = LS_SE0;
    end
  end

  // ****************************************
  // transmit handshake
  // ****************************************
  // a slow transceiver holds ready back, so the link must wait
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_cnt_r <= 4'h0;
    end else if (!utmi.tx_valid) begin
      tx_cnt_r <= 4'h0;
    end else if (tx_cnt_r != 4'hf) begin
      tx_cnt_r <= tx_cnt_r + 4'h1;
    end
  end
  assign tx_ready = utmi.tx_valid && (tx_cnt_r >= rdy_dly);
endmodule
`default_nettype wire

//--- testbench.sv
// self-checking testbench for the attach, reset and chirp sequencer
`timescale 1ns/100ps
`default_nettype none
module testbench import uarcs_pkg::*; ;
  localparam int DEB = 200;
  localparam int RST_C = 20000;
  localparam int CHK = 300;
  localparam int F_XCVR = 0;
  localparam int F_OPM = 1;
  localparam int F_TXV = 2;
  localparam int F_DATA = 3;
  localparam int F_TERM = 4;
  logic clk, rst, wr, rd, far_on, far_vbus, tx_ready, vbus_valid;
  logic [3:0] addr, rdy_dly;
  logic [31:0] wdata, rdata, d;
  logic [1:0] far_ls, line_state;
  logic [1:0] pat [9];
  uarcs_utmi_type utmi;
  int n_mismatch = 0;
  int n_compared = 0;
  int n, tot;

  uarcs_seq #(.DEB_CYC(DEB), .RST_CYC(RST_C), .CHK_CYC(CHK), .FLT_CYC(5))
  i_uarcs_seq (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .vbus_valid(vbus_valid),
    .line_state(line_state), .tx_ready(tx_ready), .utmi(utmi));

  uarcs_xcvr_model i_uarcs_xcvr_model (.clk(clk), .rst(rst), .utmi(utmi),
    .far_on(far_on), .far_ls(far_ls), .far_vbus(far_vbus),
    .rdy_dly(rdy_dly), .line_state(line_state), .vbus_valid(vbus_valid),
    .tx_ready(tx_ready));

  always #10 clk = ~clk;

  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask

  function automatic logic [7:0] fld(input int sel);
    case (sel)
      F_XCVR: fld = {6'h0, utmi.xcvr_sel};
      F_OPM: fld = {6'h0, utmi.opmode};
      F_TXV: fld = {7'h0, utmi.tx_valid};
      F_DATA: fld = utmi.tx_data;
      default: fld = {7'h0, utmi.term_sel};
    endcase
  endfunction

  task automatic wait_fld(input int sel, input logic [7:0] val,
                          input int lim, output int cyc);
    cyc = 0;
    while (fld(sel) !== val) begin
      @(posedge clk);
      #1;
      cyc++;
      if (cyc > lim) begin
        n_mismatch++;
        $display("ERROR field %0d expected %h seen %h", sel, val, fld(sel));
        end_of_test();
      end
    end
  endtask

  task automatic far(input logic on, input logic [1:0] ls, input int cyc);
    @(posedge clk);
    far_on <= on;
    far_ls <= ls;
    repeat (cyc) @(posedge clk);
    #1;
  endtask

  // ****************************************
  // sequence
  // ****************************************
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    addr = 4'h0;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    far_on = 1'b0;
    far_ls = LS_SE0;
    far_vbus = 1'b0;
    rdy_dly = 4'h3;
    pat = '{LS_K, LS_J, LS_K, LS_J, LS_SE0, LS_K, LS_J, LS_K, LS_J};
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check("xcvr idle", fld(F_XCVR), XCVR_FS);
    d = {29'h0, utmi.term_sel, utmi.tx_valid, utmi.vbus_drive};
    check("outs idle", d, 32'h0);
    rd_reg(ADDR_STAT, d);
    check("status idle", d, 32'h0);
    rd_reg(4'h8, d);
    check("unmapped read", d, 32'h0);
    $display("test reset done");

    // host: power, attach, bus reset, chirps, first sof
    wr_reg(ADDR_CTRL, 32'h3);
    wait_fld(F_TERM, 8'h1, 10, n);
    check("host fs", fld(F_XCVR), XCVR_FS);
    check("pulldowns on", {utmi.dp_pulldown, utmi.dm_pulldown}, 2'h3);
    check("vbus drive", utmi.vbus_drive, 1'b1);
    far(1'b1, LS_J, 0);
    wait_fld(F_XCVR, XCVR_HS, DEB + 200, n);
    check("attach debounce", n >= DEB, 1'b1);
    check("reset term low", utmi.term_sel, 1'b0);
    far(1'b1, LS_K, 10);
    wait_fld(F_OPM, OPM_CHIRP, 20, n);
    far(1'b0, LS_SE0, 0);
    wait_fld(F_TXV, 8'h1, 20, n);
    check("first chirp k", fld(F_DATA), CHIRP_K_DATA);
    wait_fld(F_DATA, CHIRP_J_DATA, SLOT_MAX_CYC, n);
    check("slot length", n >= SLOT_MIN_CYC && n <= SLOT_MAX_CYC, 1'b1);
    tot = n;
    wait_fld(F_DATA, SOF_PID, RST_C, n);
    tot += n;
    check("chirp period", tot > RST_C - 200 && tot <= RST_C, 1'b1);
    check("sof opmode", fld(F_OPM), OPM_NORMAL);
    check("sof valid", utmi.tx_valid, 1'b1);
    wait_fld(F_TXV, 8'h0, 20, n);
    check("sof held", n >= 3, 1'b1);
    rd_reg(ADDR_STAT, d);
    check("host run", {d[6], d[3:0]}, {1'b1, ST_H_RUN});
    wr_reg(ADDR_CTRL, 32'h7);
    @(posedge clk);
    #1;
    check("restart", {fld(F_XCVR), utmi.vbus_drive}, {XCVR_FS, 1'b0});
    wr_reg(ADDR_CTRL, 32'h0);
    repeat (2) @(posedge clk);
    #1;
    check("disable", {fld(F_XCVR), utmi.vbus_drive}, {XCVR_FS, 1'b0});
    $display("test host done");

    // device: attach, reset, chirp k, pair count with a broken sequence
    far(1'b1, LS_SE0, 0);
    wr_reg(ADDR_CTRL, 32'h1);
    far_vbus <= 1'b1;
    wait_fld(F_TERM, 8'h1, 10, n);
    check("dev fs", fld(F_XCVR), XCVR_FS);
    check("pulldowns off", {utmi.dp_pulldown, utmi.dm_pulldown}, 2'h0);
    wait_fld(F_TXV, 8'h1, DEB + 200, n);
    check("dev debounce", n >= DEB, 1'b1);
    check("chirp xcvr", fld(F_XCVR), XCVR_HS);
    check("chirp opmode", fld(F_OPM), OPM_CHIRP);
    check("chirp data", fld(F_DATA), CHIRP_K_DATA);
    wait_fld(F_TXV, 8'h0, CHK + 50, n);
    check("chirp length", n >= CHK, 1'b1);
    for (int i = 0; i < 9; i++) begin
      far(1'b1, pat[i], 20);
    end
    check("count restart", utmi.term_sel, 1'b1);
    rd_reg(ADDR_STAT, d);
    check("pairs after break", {d[9:8], d[5:4]}, {LS_J, 2'h2});
    far(1'b1, LS_K, 20);
    far(1'b1, LS_J, 20);
    check("hs term", {fld(F_TERM), fld(F_OPM)}, {1'b0, OPM_NORMAL});
    rd_reg(ADDR_STAT, d);
    check("dev hs", {d[6], d[3:0]}, {1'b1, ST_D_HS});
    @(posedge clk);
    far_vbus <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check("vbus loss", {fld(F_XCVR), utmi.term_sel}, {XCVR_FS, 1'b0});
    $display("test device done");
    end_of_test();
  end
endmodule
`default_nettype wire
